//--- core/general_purpose_pad_port.sv
// Local design decisions: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RULE1 - each pad chooses input, output or internally driven alternate function
// RULE2 - input pads are read only and return the synchronised pad level
// RULE3 - output pads take a written level, read it back, read no input
// RULE4 - alternate pads follow their function logic, not user writes
// RULE5 - every pad is an input once reset is over
// RULE6 - alarm pad is driven high while reset is held
// RULE7 - other pads are undriven during reset; far side must not rely on them
// RULE8 - pads 1,4,5,6,7: jamming, inhibit, monitor, alarm, buzzer functions
// RULE9 - pads 2,3,8,9: voice word align, receive, transmit, bit clock
// RULE10 - output pads drive both levels actively
// RULE11 - inhibit pad low stops the transmitter; application holds it high
// RULE12 - monitor pad high while transmitting, low once activity ends
// RULE13 - monitor rises 300ms before first burst, falls 500ms to 1s after last
// RULE14 - monitor stays high for a whole voice call
// RULE15 - a host command selects the monitor behaviour
// RULE16 - alarm pad rises on alarm, holds until clear command, then falls
// RULE17 - buzzer pad drives square waves for an external buzzer driver
// RULE18 - two-bit mode field per pad resets to input; unknown codes stay input
// RULE19 - pad levels pass two flip-flops before any use
module general_purpose_pad_port #(
	parameter int LEAD_CY = gpio_pkg::LEAD_CYCLES,
	parameter int TAIL_MIN = gpio_pkg::TAIL_MIN_CY,
	parameter int TAIL_MAX = gpio_pkg::TAIL_MAX_CY
) (
	// clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  rst_n,
	// avalon-mm slave
	input  wire logic [7:0]            address,
	input  wire logic                  read,
	input  wire logic                  write,
	input  wire logic [31:0]           writedata,
	output logic      [31:0]           readdata,
	output logic                       waitrequest,
	// pads
	input  wire logic [8:0]            padIn,
	output logic      [8:0]            padOut,
	output logic      [8:0]            padOe_n,
	// radio and firmware functions
	input  wire logic                  txRequest,
	input  wire logic                  callActive,
	input  wire logic                  alarmFire,
	input  wire logic                  jammingDetect,
	output logic                       txEnable,
	// voice link
	input  wire gpio_pkg::voice_link_s voiceOut,
	output logic                       voiceRxData
);

	typedef enum logic [1:0] {MON_IDLE, MON_LEAD, MON_ACTIVE, MON_TAIL} mon_state_e;

	function automatic gpio_pkg::pad_mode_e padMode(input logic [17:0] modes, input int idx);
		logic [1:0] code;
		code = modes[2*idx +: 2];
		// unknown code falls back to input
		if (code == gpio_pkg::PAD_OUTPUT)
			return gpio_pkg::PAD_OUTPUT;
		else if (code == gpio_pkg::PAD_ALT)
			return gpio_pkg::PAD_ALT;
		else
			return gpio_pkg::PAD_INPUT;  // [RULE18]
	endfunction

	logic [17:0]                 modeReg;
	logic [8:0]                  levelReg;
	logic [8:0]                  padSync;
	logic [8:0]                  altLevel;
	logic [gpio_pkg::TONE_WIDTH-1:0] toneReg;
	logic                        toneEnReg;
	logic                        toneWave;
	logic                        monLongReg;
	logic                        alarmReg;
	logic                        inhibitReg;
	logic                        monitorReg;
	logic                        alarmClear;
	logic                        busRead;
	logic                        busWrite;
	mon_state_e                  monState;
	mon_state_e                  monState_next;
	logic [31:0]                 monCount;
	logic [31:0]                 monCount_next;
	logic [31:0]                 tailLen;
	logic                        wantTx;

	// ----------------------------------------
	// pad synchroniser and buzzer
	// ----------------------------------------
	pad_sync #(.WIDTH(9)) padSyncInst (
		.core_clk(core_clk),
		.rst_n   (rst_n),
		.asyncIn (padIn),
		.syncOut (padSync)
	);

	tone_gen #(.WIDTH(gpio_pkg::TONE_WIDTH)) toneInst (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.enable    (toneEnReg),
		.halfPeriod(toneReg),
		.toneOut   (toneWave)
	);

	// ----------------------------------------
	// avalon slave
	// ----------------------------------------
	// one wait state: readdata is loaded on the first edge and stands at the second
	assign busRead  = read && !waitrequest;
	assign busWrite = write && !waitrequest;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			waitrequest <= 1'b1;
		else
			waitrequest <= !((read || write) && waitrequest);
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			readdata <= '0;
		end else if (read && waitrequest) begin
			unique case (address)
				gpio_pkg::ADDR_MODE:   readdata <= {14'h0000, modeReg};
				gpio_pkg::ADDR_LEVEL:  readdata <= {23'h000000, levelReg};  // [RULE3]
				gpio_pkg::ADDR_TONE:   readdata <= {toneEnReg, 7'h00, toneReg};
				gpio_pkg::ADDR_CTRL:
					readdata <= {30'h00000000, monLongReg, 1'b0};
				gpio_pkg::ADDR_STATUS:
					readdata <= {28'h0000000, txEnable, monitorReg, inhibitReg, alarmReg};
				gpio_pkg::ADDR_INPUT: begin
					for (int i = 0; i < 9; i++)
						readdata[i] <= (padMode(modeReg, i) == gpio_pkg::PAD_INPUT) &&
							padSync[i];  // [RULE2]
					readdata[31:9] <= '0;
				end
				default: readdata <= '0;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			modeReg    <= gpio_pkg::MODE_RESET;  // [RULE5]
			levelReg   <= gpio_pkg::LEVEL_RESET;
			toneReg    <= gpio_pkg::TONE_RESET;
			toneEnReg  <= 1'b0;
			monLongReg <= 1'b0;
		end else if (busWrite) begin
			unique case (address)
				gpio_pkg::ADDR_MODE:  modeReg  <= writedata[17:0];  // [RULE1]
				gpio_pkg::ADDR_LEVEL: levelReg <= writedata[8:0];  // [RULE3]
				gpio_pkg::ADDR_CTRL:  monLongReg <= writedata[gpio_pkg::CTRL_LONG];  // [RULE15]
				gpio_pkg::ADDR_TONE: begin
					toneReg   <= writedata[gpio_pkg::TONE_WIDTH-1:0];
					toneEnReg <= writedata[gpio_pkg::TONE_EN];
				end
				default: ;
			endcase
		end
	end

	assign alarmClear = busWrite && (address == gpio_pkg::ADDR_CTRL) &&
		writedata[gpio_pkg::CTRL_CLEAR];

	// ----------------------------------------
	// alarm, inhibit and voice receive
	// ----------------------------------------
	// a fresh alarm in the clearing cycle survives the clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			alarmReg <= 1'b0;
		else if (alarmFire)
			alarmReg <= 1'b1;  // [RULE16]
		else if (alarmClear)
			alarmReg <= 1'b0;  // [RULE16]
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			inhibitReg <= 1'b0;
		else
			inhibitReg <= (padMode(modeReg, gpio_pkg::PAD_INHIBIT) == gpio_pkg::PAD_ALT) &&
				!padSync[gpio_pkg::PAD_INHIBIT];  // [RULE11]
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			voiceRxData <= 1'b0;
		else
			voiceRxData <= (padMode(modeReg, gpio_pkg::PAD_RXD) == gpio_pkg::PAD_ALT) &&
				padSync[gpio_pkg::PAD_RXD];  // [RULE9]
	end

	// ----------------------------------------
	// transmit monitor
	// ----------------------------------------
	// the radio waits for txEnable, so the lead time is met by holding off bursts
	assign wantTx  = txRequest || callActive;  // [RULE14]
	assign tailLen = monLongReg ? 32'(TAIL_MAX) : 32'(TAIL_MIN);  // [RULE15]

	always_comb begin
		monState_next = monState;
		monCount_next = monCount + 32'h1;
		unique case (monState)
			MON_IDLE: begin
				monCount_next = '0;
				if (wantTx)
					monState_next = MON_LEAD;  // [RULE12]
			end
			MON_LEAD:
				if (monCount == 32'(LEAD_CY) - 32'h1)
					monState_next = MON_ACTIVE;  // [RULE13]
			MON_ACTIVE: begin
				monCount_next = '0;
				if (!wantTx)
					monState_next = MON_TAIL;
			end
			MON_TAIL:
				if (wantTx)
					monState_next = MON_ACTIVE;
				else if (monCount == tailLen - 32'h1)
					monState_next = MON_IDLE;  // [RULE13]
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			monState   <= MON_IDLE;
			monCount   <= '0;
			monitorReg <= 1'b0;
			txEnable   <= 1'b0;
		end else begin
			monState   <= monState_next;
			monCount   <= monCount_next;
			monitorReg <= monState_next != MON_IDLE;  // [RULE12]
			txEnable   <= (monState_next == MON_ACTIVE) && !inhibitReg;  // [RULE11]
		end
	end

	// ----------------------------------------
	// pad drivers
	// ----------------------------------------
	always_comb begin
		altLevel                        = '0;
		altLevel[gpio_pkg::PAD_JAM]     = jammingDetect;  // [RULE8]
		altLevel[gpio_pkg::PAD_WORD]    = voiceOut.wordAlign;  // [RULE9]
		altLevel[gpio_pkg::PAD_MONITOR] = monitorReg;
		altLevel[gpio_pkg::PAD_ALARM]   = alarmReg;
		altLevel[gpio_pkg::PAD_BUZZ]    = toneWave;  // [RULE17]
		altLevel[gpio_pkg::PAD_TXD]     = voiceOut.txData;
		altLevel[gpio_pkg::PAD_BCLK]    = voiceOut.bitClk;
	end

	for (genvar i = 0; i < 9; i++) begin : padGen
		localparam logic HELD = (i == gpio_pkg::PAD_ALARM);
		gpio_pkg::pad_mode_e mode;
		assign mode = padMode(modeReg, i);

		// alarm pad is driven high through reset; the rest float
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				padOe_n[i] <= !HELD;  // [RULE6] [RULE7]
				padOut[i]  <= HELD;  // [RULE6]
			end else begin
				padOe_n[i] <= !((mode == gpio_pkg::PAD_OUTPUT) ||
					((mode == gpio_pkg::PAD_ALT) && !gpio_pkg::ALT_IN_MASK[i]));  // [RULE10]
				padOut[i]  <= (mode == gpio_pkg::PAD_OUTPUT) ? levelReg[i] :
					(mode == gpio_pkg::PAD_ALT) ? altLevel[i] : 1'b0;  // [RULE4]
			end
		end

		pad_float_a: assert property (  // [RULE5]
			@(posedge core_clk) disable iff (!rst_n)
			mode == gpio_pkg::PAD_INPUT |=> padOe_n[i])
			else $error("input pad driven");

		pad_level_a: assert property (  // [RULE3]
			@(posedge core_clk) disable iff (!rst_n)
			mode == gpio_pkg::PAD_OUTPUT |=> !padOe_n[i] && padOut[i] == $past(levelReg[i]))
			else $error("output pad not at written level");

		pad_alt_a: assert property (  // [RULE4]
			@(posedge core_clk) disable iff (!rst_n)
			mode == gpio_pkg::PAD_ALT && !gpio_pkg::ALT_IN_MASK[i] |=>
				padOut[i] == $past(altLevel[i]))
			else $error("alternate pad not following its function");
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	alarm_hold_a: assert property (  // [RULE16]
		@(posedge core_clk) disable iff (!rst_n)
		alarmReg && !alarmClear |=> alarmReg)
		else $error("alarm dropped without clear");

	alarm_clear_a: assert property (  // [RULE16]
		@(posedge core_clk) disable iff (!rst_n)
		alarmClear && !alarmFire |=> !alarmReg)
		else $error("alarm not cleared");

	inhibit_stop_a: assert property (  // [RULE11]
		@(posedge core_clk) disable iff (!rst_n)
		inhibitReg |=> !txEnable)
		else $error("transmit enabled while inhibited");

	lead_before_a: assert property (  // [RULE13]
		@(posedge core_clk) disable iff (!rst_n)
		$rose(txEnable) |-> $past(monitorReg, 2))
		else $error("transmit granted without monitor lead");

	tail_hold_a: assert property (  // [RULE13]
		@(posedge core_clk) disable iff (!rst_n)
		monState == MON_ACTIVE && monState_next == MON_TAIL |=> monitorReg [*8])
		else $error("monitor fell early after last burst");

	call_high_a: assert property (  // [RULE14]
		@(posedge core_clk) disable iff (!rst_n)
		monState == MON_ACTIVE && callActive |=> monitorReg)
		else $error("monitor low during call");

	bus_answer_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
		else $error("bus answer not one wait state");

endmodule

`default_nettype wire

//--- core/gpio_pkg.sv
package gpio_pkg;

	// ----------------------------------------
	// pads and modes
	// ----------------------------------------
	localparam int         PAD_COUNT   = 9;
	localparam int         PAD_JAM     = 0;
	localparam int         PAD_WORD    = 1;
	localparam int         PAD_RXD     = 2;
	localparam int         PAD_INHIBIT = 3;
	localparam int         PAD_MONITOR = 4;
	localparam int         PAD_ALARM   = 5;
	localparam int         PAD_BUZZ    = 6;
	localparam int         PAD_TXD     = 7;
	localparam int         PAD_BCLK    = 8;
	localparam logic [8:0] ALT_IN_MASK = 9'h00c;

	typedef enum logic [1:0] {
		PAD_INPUT  = 2'h0,
		PAD_OUTPUT = 2'h1,
		PAD_ALT    = 2'h2
	} pad_mode_e;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0]  ADDR_MODE    = 8'h00;
	localparam logic [7:0]  ADDR_LEVEL   = 8'h04;
	localparam logic [7:0]  ADDR_INPUT   = 8'h08;
	localparam logic [7:0]  ADDR_CTRL    = 8'h0c;
	localparam logic [7:0]  ADDR_TONE    = 8'h10;
	localparam logic [7:0]  ADDR_STATUS  = 8'h14;
	localparam logic [17:0] MODE_RESET   = 18'h00000;
	localparam logic [8:0]  LEVEL_RESET  = 9'h000;
	localparam int          CTRL_CLEAR   = 0;
	localparam int          CTRL_LONG    = 1;
	localparam int          TONE_WIDTH   = 24;
	localparam int          TONE_EN      = 31;
	localparam logic [23:0] TONE_RESET   = 24'h000000;
	localparam int          ST_ALARM     = 0;
	localparam int          ST_INHIBIT   = 1;
	localparam int          ST_MONITOR   = 2;
	localparam int          ST_GRANT     = 3;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_KHZ     = 250_000;
	localparam int LEAD_MS     = 300;
	localparam int TAIL_MIN_MS = 500;
	localparam int TAIL_MAX_MS = 1000;
	localparam int LEAD_CYCLES = CLK_KHZ * LEAD_MS;
	localparam int TAIL_MIN_CY = CLK_KHZ * TAIL_MIN_MS;
	localparam int TAIL_MAX_CY = CLK_KHZ * TAIL_MAX_MS;

	// ----------------------------------------
	// voice link carrier
	// ----------------------------------------
	typedef struct packed {
		logic wordAlign;
		logic txData;
		logic bitClk;
	} voice_link_s;

endpackage

//--- core/pad_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pad_sync #(
	parameter int WIDTH = 9
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	// levels
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1Reg;

	// first stage feeds only the second
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1Reg <= '0;
			syncOut   <= '0;
		end else begin
			stage1Reg <= asyncIn;  // [RULE19]
			syncOut   <= stage1Reg;
		end
	end

endmodule

`default_nettype wire

//--- core/tone_gen.sv
`timescale 1ns/1ps
`default_nettype none

module tone_gen #(
	parameter int WIDTH = 24
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	// control
	input  wire logic             enable,
	input  wire logic [WIDTH-1:0] halfPeriod,
	// square wave
	output logic                  toneOut
);

	logic [WIDTH-1:0] countReg;

	// a zero half period behaves as one so the wave never stalls high
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			countReg <= '0;
			toneOut  <= 1'b0;
		end else if (!enable) begin
			countReg <= '0;
			toneOut  <= 1'b0;
		end else if (countReg + WIDTH'(1) >= halfPeriod) begin
			countReg <= '0;
			toneOut  <= !toneOut;  // [RULE17]
		end else begin
			countReg <= countReg + WIDTH'(1);
		end
	end

	tone_quiet_a: assert property (  // [RULE17]
		@(posedge core_clk) disable iff (!rst_n) !enable |=> !toneOut)
		else $error("tone active while disabled");

endmodule

`default_nettype wire

//--- sim/pad_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module pad_host_model (
	// clock
	input  wire logic       core_clk,
	// device side of the pads
	input  wire logic [8:0] padOut,
	input  wire logic [8:0] padOe_n,
	// application side
	input  wire logic [8:0] hostLevel,
	input  wire logic [8:0] hostDrive,
	output logic      [8:0] padIn
);
	logic wobble;

	initial wobble = 1'b0;
	always @(posedge core_clk) begin
		wobble <= ~wobble;
	end

	// floating pads wobble so a stale level never looks valid
	// pad 4 has its pull-up, so the inhibit line idles high
	always_comb begin
		for (int i = 0; i < 9; i++) begin
			if (padOe_n[i] === 1'b0)
				padIn[i] = padOut[i];
			else if (hostDrive[i])
				padIn[i] = hostLevel[i];
			else if (i == 3)
				padIn[i] = 1'b1;
			else
				padIn[i] = wobble ^ i[0];
		end
	end
endmodule

`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam int LEAD = 20;
	localparam int TMIN = 40;
	localparam int TMAX = 80;
	logic                 core_clk = 1'b0;
	logic                 rst_n = 1'b0;
	logic [7:0]           address = 8'h00;
	logic                 read = 1'b0;
	logic                 write = 1'b0;
	logic [31:0]          writedata = 32'h0;
	logic [31:0]          readdata;
	logic                 waitrequest;
	logic [8:0]           padIn;
	logic [8:0]           padOut;
	logic [8:0]           padOe_n;
	logic                 txRequest = 1'b0;
	logic                 callActive = 1'b0;
	logic                 alarmFire = 1'b0;
	logic                 jammingDetect = 1'b0;
	logic                 txEnable;
	gpio_pkg::voice_link_s voiceOut = '0;
	logic                 voiceRxData;
	logic [8:0]           hostLevel = 9'h1ff;
	logic [8:0]           hostDrive = 9'h1ff;
	logic [31:0]          q;
	int                   err_count = 0;
	int                   cmp_count = 0;

	always #2 core_clk = ~core_clk;

	general_purpose_pad_port #(.LEAD_CY(LEAD), .TAIL_MIN(TMIN), .TAIL_MAX(TMAX))
	u_general_purpose_pad_port (.core_clk(core_clk), .rst_n(rst_n), .address(address),
		.read(read), .write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .padIn(padIn), .padOut(padOut), .padOe_n(padOe_n),
		.txRequest(txRequest), .callActive(callActive), .alarmFire(alarmFire),
		.jammingDetect(jammingDetect), .txEnable(txEnable), .voiceOut(voiceOut),
		.voiceRxData(voiceRxData));

	pad_host_model u_pad_host_model (.core_clk(core_clk), .padOut(padOut),
		.padOe_n(padOe_n), .hostLevel(hostLevel), .hostDrive(hostDrive), .padIn(padIn));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// request held until waitrequest is seen low at an edge
	// only the watchdog ends a wait that never gets its answer
	task automatic bus(input int wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		address <= a;
		writedata <= d;
		read <= (wr == 0);
		write <= (wr != 0);
		do begin
			@(posedge core_clk);
		end while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	function automatic logic pick(input int w);
		return (w < 0) ? txEnable : padOut[w];
	endfunction

	// counts edges until the watched output reaches v, expects lo..hi
	task automatic await_level(input int w, input logic v, input int lo, input int hi);
		int n;
		n = 0;
		while (pick(w) !== v && n < hi + 5) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk(32'(n >= lo && n <= hi), 32'h1);
	endtask

	// ----------------------------------------
	// watchdog: whole run is well under a thousand cycles
	// ----------------------------------------
	initial begin
		#40000;
		err_count++;
		$display("Error t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		print_verdict();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		int edges;
		logic last;
		settle(15);
		chk(32'(padOe_n), 32'h1df);
		chk(32'(padOut[5]), 32'h1);
		@(posedge core_clk) rst_n <= 1'b1;
		settle(2);
		chk(32'(padOe_n), 32'h1ff);
		bus(0, gpio_pkg::ADDR_MODE, 0);
		chk(q, 32'h0);
		bus(0, 8'h3c, 0);
		chk(q, 32'h0);
		// inputs report the pad level; a level write reaches no pad
		@(posedge core_clk) hostLevel <= 9'h0a5;
		bus(1, gpio_pkg::ADDR_LEVEL, 32'h1ff);
		settle(4);
		chk(32'(padOe_n), 32'h1ff);
		bus(0, gpio_pkg::ADDR_INPUT, 0);
		chk(q, 32'h0a5);
		// outputs: push-pull, read back, no input
		bus(1, gpio_pkg::ADDR_MODE, 32'h15555);
		bus(1, gpio_pkg::ADDR_LEVEL, 32'h05a);
		settle(2);
		chk(32'({padOe_n, padOut}), 32'({9'h000, 9'h05a}));
		bus(0, gpio_pkg::ADDR_LEVEL, 0);
		chk(q, 32'h05a);
		bus(0, gpio_pkg::ADDR_INPUT, 0);
		chk(q, 32'h0);
		bus(1, gpio_pkg::ADDR_MODE, 32'h3ffff);
		settle(2);
		chk(32'(padOe_n), 32'h1ff);
		// alternate: function logic owns the pads
		@(posedge core_clk) hostLevel <= 9'h1ff;
		bus(1, gpio_pkg::ADDR_MODE, 32'h2aaaa);
		bus(1, gpio_pkg::ADDR_LEVEL, 32'h000);
		@(posedge core_clk);
		voiceOut <= 3'b101;
		jammingDetect <= 1'b1;
		settle(3);
		chk(32'(padOe_n), 32'(gpio_pkg::ALT_IN_MASK));
		chk(32'({padOut[8], padOut[7], padOut[1], padOut[0]}), 32'h00b);
		chk(32'(voiceRxData), 32'h1);
		@(posedge core_clk);
		voiceOut <= 3'b010;
		jammingDetect <= 1'b0;
		hostLevel[2] <= 1'b0;
		settle(5);
		chk(32'({padOut[8], padOut[7], padOut[1], padOut[0]}), 32'h004);
		chk(32'(voiceRxData), 32'h0);
		// monitor: lead before grant, short then long tail
		for (int t = 0; t < 2; t++) begin
			bus(1, gpio_pkg::ADDR_CTRL, 32'(t) << 1);
			@(posedge core_clk) txRequest <= 1'b1;
			await_level(4, 1'b1, 1, 2);
			chk(32'(txEnable), 32'h0);
			await_level(-1, 1'b1, LEAD - 2, LEAD + 3);
			@(posedge core_clk) txRequest <= 1'b0;
			await_level(-1, 1'b0, 1, 2);
			await_level(4, 1'b0, (t ? TMAX : TMIN) - 3, (t ? TMAX : TMIN) + 2);
		end
		// a call keeps the monitor up throughout
		@(posedge core_clk) callActive <= 1'b1;
		await_level(4, 1'b1, 1, 2);
		edges = 0;
		repeat (150) begin
			settle(1);
			edges += 32'(padOut[4] !== 1'b1);
		end
		chk(32'(edges), 32'h0);
		chk(32'(txEnable), 32'h1);
		bus(0, gpio_pkg::ADDR_STATUS, 0);
		chk(q, 32'h00c);
		// application pulls the inhibit pad low mid-call, then leaves it to the pull-up
		@(posedge core_clk) hostLevel[3] <= 1'b0;
		await_level(-1, 1'b0, 1, 6);
		@(posedge core_clk) callActive <= 1'b0;
		hostDrive[3] <= 1'b0;
		await_level(4, 1'b0, TMAX - 3, TMAX + 2);
		// alarm holds until the clear command
		@(posedge core_clk) alarmFire <= 1'b1;
		@(posedge core_clk) alarmFire <= 1'b0;
		await_level(5, 1'b1, 0, 2);
		settle(30);
		chk(32'(padOut[5]), 32'h1);
		bus(0, gpio_pkg::ADDR_STATUS, 0);
		chk(q & 32'h1, 32'h1);
		bus(1, gpio_pkg::ADDR_CTRL, 32'h1);
		await_level(5, 1'b0, 0, 2);
		// buzzer square wave, half period of 4 cycles
		bus(1, gpio_pkg::ADDR_TONE, 32'h80000004);
		settle(4);
		edges = 0;
		last = padOut[6];
		repeat (80) begin
			settle(1);
			edges += 32'(padOut[6] !== last);
			last = padOut[6];
		end
		chk(32'(edges >= 19 && edges <= 21), 32'h1);
		print_verdict();
	end
endmodule

`default_nettype wire
